// ---- design/ascc_core.sv ----
// Serial control and conversion sequencing of an 8-channel 10-bit SAR converter
// How it works
// - Differential: low select bits pick pair, top bit swaps polarity.
// - Result frame: leading zero, ten result bits, two sub-bits, three zeros.
// - Unipolar gives straight binary, bipolar gives two's complement.
// - Serial output changes on falling serial clock edges, MSB first.
// - Sample is acquired during the last three command bits.
// - External mode: strobe high one serial clock after last command bit.
// - External mode: one decision on each of next 12 falling edges.
// - External mode: deselect floats strobe and output; reselect drives strobe low.
// - Internal mode: strobe low during conversion, at most 10 us.
// - Internal mode: result held, MSB on first falling edge after strobe rises.
// - Internal mode: deselect blocks input, floats output, conversion continues.
// - Select edge alone starts nothing; first high bit is the start bit.
// - Conversion begins on falling edge after eighth command bit.
// - Start bit accepted when idle, or after result bit three is shown.
// - Select edge with early start bit abandons conversion and restarts.
// - Serial input sampled on rising serial clock edges while selected.
// - Command bits: start, channel, unipolar, single-ended, power/clock mode.
// - Mode bits: 00 full down, 01 fast down, 10 internal, 11 external.
`timescale 1ns/100ps
module ascc_core
  import ascc_pkg::*;
#(
  parameter int CONV_CYCLES = INT_CONV_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Serial pins
  input wire logic CHIP_SELECT_N,
  input wire logic SERIAL_CLOCK,
  input wire logic SERIAL_DATA_IN,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OUT_OE_N,
  output logic CONVERSION_STROBE,
  output logic CONVERSION_STROBE_OE_N,
  // Analog front end control
  output ascc_pkg::ascc_analog_type ANALOG_CONTROL,
  output ascc_pkg::ascc_cmd_type ACTIVE_COMMAND,
  output logic CONVERTING,
  // Comparator result from the analog core, one word per conversion
  input wire logic [RES_BITS-1:0] CONVERTER_RESULT,
  input wire logic [1:0] CONVERTER_SUB_BITS
);
  import ascc_pkg::*;

  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] sck_sync;
    logic [1:0] din_sync;
    logic sck_last;
    logic cs_last;
    ascc_state_type state;
    logic [3:0] bit_cnt;
    logic [CMD_BITS-1:0] shift_in;
    ascc_cmd_type cmd;
    logic [FRAME_BITS-1:0] frame;
    logic [4:0] out_cnt;
    logic b3_seen;
    logic ext_pending;
    logic int_ready;
    logic converting;
    logic [CNT_W-1:0] conv_cnt;
    logic dout;
    logic dout_oe_n;
    logic strobe;
    logic strobe_oe_n;
    ascc_analog_type analog;
  } ascc_core_state_type;

  ascc_core_state_type r;
  ascc_core_state_type next_r;

  // Channel mux mapping for single-ended and differential inputs
  function automatic ascc_analog_type map_inputs(input ascc_cmd_type c, input logic smp);
    ascc_analog_type a;
    logic [2:0] ch;
    ch = {c.channel_select[0], c.channel_select[2], c.channel_select[1]};
    a.unipolar = c.polarity_select;
    a.sample = smp;
    if (c.input_config_select) begin
      a.mux_positive = {1'b0, ch};
      a.mux_negative = 4'h8;
    end else begin
      a.mux_positive = {1'b0, c.channel_select[1:0], c.channel_select[2]};
      a.mux_negative = {1'b0, c.channel_select[1:0], ~c.channel_select[2]};
    end
    return a;
  endfunction

  // Result coding and frame build
  function automatic logic [FRAME_BITS-1:0] build_frame(input logic [RES_BITS-1:0] res,
      input logic [1:0] sub, input logic uni);
    logic [RES_BITS-1:0] coded;
    coded = uni ? res : {~res[RES_BITS-1], res[RES_BITS-2:0]};
    return {1'b0, coded, sub, 3'h0};
  endfunction

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_low;
  logic din;
  logic start_ok;

  always_comb begin
    sck_rise = r.sck_sync[1] & ~r.sck_last;
    sck_fall = ~r.sck_sync[1] & r.sck_last;
    cs_low = ~r.cs_sync[1];
    cs_fall = cs_low & r.cs_last;
    din = r.din_sync[1];
    start_ok = !r.converting || r.b3_seen;
    next_r = r;
    next_r.cs_sync = {r.cs_sync[0], CHIP_SELECT_N};
    next_r.sck_sync = {r.sck_sync[0], SERIAL_CLOCK};
    next_r.din_sync = {r.din_sync[0], SERIAL_DATA_IN};
    next_r.sck_last = r.sck_sync[1];
    next_r.cs_last = r.cs_sync[1];
    next_r.analog.sample = 1'b0;

    // Reselect drives the strobe low again in external mode
    if (cs_fall) begin
      next_r.dout_oe_n = 1'b0;
      if (r.strobe_oe_n) begin
        next_r.strobe = 1'b0;
      end
      next_r.strobe_oe_n = 1'b0;
      // Early restart abandons a running conversion before result bit 3
      // A finished internal result stays readable across reselect
      if (r.converting && !r.b3_seen) begin
        next_r.state = ST_IDLE;
        next_r.bit_cnt = 4'h0;
        next_r.ext_pending = 1'b0;
        next_r.strobe = 1'b0;
        next_r.out_cnt = 5'h0;
        next_r.frame = '0;
      end
    end

    // Command shift on rising edges while selected
    if (cs_low && sck_rise) begin
      if (r.bit_cnt == 4'h0) begin
        if (din && start_ok && !cs_fall) begin
          next_r.bit_cnt = 4'h1;
          next_r.shift_in = {{(CMD_BITS-1){1'b0}}, 1'b1};
        end
      end else if (r.bit_cnt < 4'h8) begin
        next_r.shift_in = {r.shift_in[CMD_BITS-2:0], din};
        next_r.bit_cnt = r.bit_cnt + 4'h1;
        if (r.bit_cnt >= 4'h5) begin
          next_r.analog = map_inputs(ascc_cmd_type'({r.shift_in[5:0], din}), 1'b1);
          next_r.analog.sample = 1'b1;
        end
        if (r.bit_cnt == 4'h7) begin
          next_r.cmd = ascc_cmd_type'({r.shift_in[5:0], din});
          next_r.ext_pending = 1'b1;
        end
      end
    end

    // Conversion begins on the falling edge after the eighth bit
    if (sck_fall && r.ext_pending) begin
      next_r.ext_pending = 1'b0;
      next_r.bit_cnt = 4'h0;
      next_r.b3_seen = 1'b0;
      next_r.out_cnt = 5'h0;
      next_r.dout = 1'b0;
      unique case (r.cmd.power_clock_mode)
        MODE_EXT_CLK: begin
          next_r.state = ST_EXT;
          next_r.strobe = 1'b1;
          // Leading zero goes out now; the rest follows on the next falls
          next_r.frame = build_frame(CONVERTER_RESULT, CONVERTER_SUB_BITS,
            r.cmd.polarity_select) << 1;
          next_r.out_cnt = 5'h1;
        end
        MODE_INT_CLK, MODE_FULL_PD, MODE_FAST_PD: begin
          next_r.state = ST_INT;
          next_r.strobe = 1'b0;
          next_r.int_ready = 1'b0;
          next_r.conv_cnt = '0;
        end
      endcase
    end else if (sck_fall && r.state == ST_EXT) begin
      next_r.strobe = 1'b0;
      next_r.dout = r.frame[FRAME_BITS-1];
      next_r.frame = {r.frame[FRAME_BITS-2:0], 1'b0};
      next_r.out_cnt = r.out_cnt + 5'h1;
      if (r.out_cnt == 5'(B3_FRAME_IDX)) begin
        next_r.b3_seen = 1'b1;
      end
      if (r.out_cnt == 5'(FRAME_BITS - 1)) begin
        next_r.state = ST_IDLE;
      end
    end else if (sck_fall && r.state == ST_INT && r.int_ready) begin
      next_r.dout = r.frame[FRAME_BITS-1];
      next_r.frame = {r.frame[FRAME_BITS-2:0], 1'b0};
      next_r.out_cnt = r.out_cnt + 5'h1;
      if (r.out_cnt == 5'(B3_FRAME_IDX)) begin
        next_r.b3_seen = 1'b1;
      end
    end

    // Self-timed conversion keeps running while deselected; a reselect before it ends abandons it
    if (r.state == ST_INT && !r.int_ready) begin
      next_r.conv_cnt = r.conv_cnt + 1'b1;
      if (r.conv_cnt == CNT_W'(CONV_CYCLES - 1)) begin
        next_r.int_ready = 1'b1;
        next_r.strobe = 1'b1;
        // Leading zero stands before the first fall, which brings the MSB
        next_r.dout = 1'b0;
        next_r.frame = build_frame(CONVERTER_RESULT, CONVERTER_SUB_BITS,
          r.cmd.polarity_select) << 1;
        next_r.out_cnt = 5'h1;
      end
    end

    // Deselect floats the output, and the strobe only in external mode
    if (!cs_low) begin
      next_r.dout_oe_n = 1'b1;
      if (r.cmd.power_clock_mode == MODE_EXT_CLK) begin
        next_r.strobe_oe_n = 1'b1;
      end else begin
        next_r.strobe_oe_n = 1'b0;
      end
      next_r.bit_cnt = (r.bit_cnt == 4'h8) ? r.bit_cnt : 4'h0;
    end
    next_r.converting = (next_r.state == ST_EXT) ||
      (next_r.state == ST_INT && !next_r.int_ready);
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      r <= '0;
      r.cs_sync <= 2'h3;
      r.cs_last <= 1'b1;
      r.strobe <= 1'b1;
      r.dout_oe_n <= 1'b1;
      r.cmd <= ascc_cmd_type'(CMD_RESET[6:0] | {5'h00, MODE_INT_CLK});
      r.frame <= {1'b0, RES_RESET, 5'h00};
    end else begin
      r <= next_r;
    end
  end

  assign SERIAL_DATA_OUT = r.dout;
  assign SERIAL_DATA_OUT_OE_N = r.dout_oe_n;
  assign CONVERSION_STROBE = r.strobe;
  assign CONVERSION_STROBE_OE_N = r.strobe_oe_n;
  assign ANALOG_CONTROL = r.analog;
  assign ACTIVE_COMMAND = r.cmd;
  assign CONVERTING = r.converting;
endmodule // ascc_core

// ---- inc/ascc_pkg.sv ----
// Package: constants and carrier types for the serial conversion control block
package ascc_pkg;
  localparam int RES_BITS = 10;
  localparam int CMD_BITS = 8;
  // Command byte field positions
  localparam int CMD_START_POS = 7;
  localparam int CMD_SEL_HI_POS = 6;
  localparam int CMD_SEL_LO_POS = 4;
  localparam int CMD_UNI_POS = 3;
  localparam int CMD_SGL_POS = 2;
  localparam int CMD_PD_HI_POS = 1;
  localparam int CMD_PD_LO_POS = 0;
  // Power/clock mode encodings
  localparam logic [1:0] MODE_FULL_PD = 2'h0;
  localparam logic [1:0] MODE_FAST_PD = 2'h1;
  localparam logic [1:0] MODE_INT_CLK = 2'h2;
  localparam logic [1:0] MODE_EXT_CLK = 2'h3;
  // Serial output frame: leading zero, 10 result bits, 2 sub-bits, 3 zeros
  localparam int FRAME_BITS = 16;
  // Result bit 3 appears on this output bit index of the frame (0 = leading zero)
  localparam int B3_FRAME_IDX = 7;
  localparam int EXT_DECISIONS = 12;
  // Internal conversion time
  localparam int CLK_FREQ_MHZ = 200;
  localparam int INT_CONV_NS = 10000;
  localparam int INT_CONV_CYCLES = (INT_CONV_NS * CLK_FREQ_MHZ) / 1000;
  localparam int CNT_W = 16;
  localparam logic [CMD_BITS-1:0] CMD_RESET = 8'h00;
  localparam logic [RES_BITS-1:0] RES_RESET = 10'h000;

  typedef struct packed {
    logic [2:0] channel_select;
    logic polarity_select;
    logic input_config_select;
    logic [1:0] power_clock_mode;
  } ascc_cmd_type;

  typedef struct packed {
    logic [3:0] mux_positive;
    logic [3:0] mux_negative;
    logic unipolar;
    logic sample;
  } ascc_analog_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_EXT = 2'b10,
    ST_INT = 2'b11
  } ascc_state_type;
endpackage

// ---- tb/ascc_core_properties.sv ----
// Pin-level checks for the serial conversion control block
`timescale 1ns/100ps
module ascc_core_properties
  import ascc_pkg::*;
#(
  parameter int CONV_CYCLES = 20
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Serial pins
  input wire logic CHIP_SELECT_N,
  input wire logic SERIAL_CLOCK,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_DATA_OUT_OE_N,
  input wire logic CONVERSION_STROBE,
  input wire logic CONVERSION_STROBE_OE_N,
  // Front end and status
  input wire ascc_pkg::ascc_analog_type ANALOG_CONTROL,
  input wire ascc_pkg::ascc_cmd_type ACTIVE_COMMAND,
  input wire logic CONVERTING
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  logic ext;
  logic [CNT_W-1:0] low_cnt;
  assign ext = ACTIVE_COMMAND.power_clock_mode == MODE_EXT_CLK;
  // Length of the strobe low phase of a self-clocked conversion
  always_ff @(posedge CLOCK) begin
    if (RESET || ext || CONVERSION_STROBE)
      low_cnt <= '0;
    else if (low_cnt != '1)
      low_cnt <= low_cnt + 1'b1;
  end
  a_dout_on_fall: assert property (
    $changed(SERIAL_DATA_OUT) && !SERIAL_DATA_OUT_OE_N && !$past(SERIAL_DATA_OUT_OE_N)
    |-> !SERIAL_CLOCK && !$past(SERIAL_CLOCK, 2)) else $error("output moved off a fall");
  a_dout_float: assert property (
    CHIP_SELECT_N [*8] |-> SERIAL_DATA_OUT_OE_N) else $error("output driven deselected");
  a_strobe_float: assert property (
    (ext && CHIP_SELECT_N) [*8] |-> CONVERSION_STROBE_OE_N) else $error("strobe driven");
  a_strobe_relow: assert property (
    ext && $fell(CHIP_SELECT_N) |-> ##6 !CONVERSION_STROBE_OE_N && !CONVERSION_STROBE)
    else $error("strobe not low after select");
  a_strobe_driven: assert property (
    !ext |-> !CONVERSION_STROBE_OE_N) else $error("strobe floated in internal mode");
  a_strobe_bound: assert property (
    low_cnt <= CONV_CYCLES + 16) else $error("strobe low too long");
  a_strobe_pulse: assert property (
    $rose(CONVERSION_STROBE) && ext |-> CONVERSION_STROBE [*8] ##4 CONVERSION_STROBE
    ##3 !CONVERSION_STROBE) else $error("strobe pulse not one serial period");
  a_sample_once: assert property (
    ANALOG_CONTROL.sample |-> !$past(CHIP_SELECT_N, 3) ##1 !ANALOG_CONTROL.sample)
    else $error("bad sample pulse");
  a_no_cs_start: assert property (
    $fell(CHIP_SELECT_N) && !CONVERTING |=> !CONVERTING [*8]) else $error("select started");
endmodule // ascc_core_properties

// ---- tb/ascc_host_model.sv ----
// Host serial master model: idle-low clock, data changed on falls
`timescale 1ns/100ps
module ascc_host_model (
  // Reference clock
  input wire logic clk,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe_n
);
  logic [23:0] rx;
  event got;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // Clock stands low outside frames; a floated output reads inverted
  task automatic xfer(input int n, input logic [23:0] tx);
    @(negedge clk);
    cs_n = 1'b0;
    for (int j = 0; j < n; j++) begin
      din = tx[23 - j];
      #32 sclk = 1'b1;
      rx = {rx[22:0], dout_oe_n ? ~dout : dout};
      #32 sclk = 1'b0;
    end
    #32 cs_n = 1'b1;
    din = ~din;
    if (n >= 16)
      ->got;
  endtask
endmodule // ascc_host_model

// ---- tb/ascc_core_bench.sv ----
// Self-checking bench for the serial conversion control block
`timescale 1ns/100ps
module ascc_core_bench;
  import ascc_pkg::*;
  localparam int CONV = 20;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cs_n, sclk, din, dout, dout_oe_n, strobe, strobe_oe_n, converting;
  logic [RES_BITS-1:0] result = 10'h000;
  logic [1:0] sub = 2'h0;
  ascc_analog_type analog;
  ascc_cmd_type cmd;
  logic [15:0] expq[$];
  int bad_count = 0;
  int n_tests = 0;
  always #2.5 clock = ~clock;
  ascc_core #(.CONV_CYCLES(CONV)) ascc_core_inst (.CLOCK(clock), .RESET(reset),
    .CHIP_SELECT_N(cs_n), .SERIAL_CLOCK(sclk), .SERIAL_DATA_IN(din),
    .SERIAL_DATA_OUT(dout), .SERIAL_DATA_OUT_OE_N(dout_oe_n),
    .CONVERSION_STROBE(strobe), .CONVERSION_STROBE_OE_N(strobe_oe_n),
    .ANALOG_CONTROL(analog), .ACTIVE_COMMAND(cmd), .CONVERTING(converting),
    .CONVERTER_RESULT(result), .CONVERTER_SUB_BITS(sub));
  ascc_host_model ascc_host_model_inst (.clk(clock), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout(dout), .dout_oe_n(dout_oe_n));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    if (expq.size() != 0)
      bad_count++;
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(ascc_host_model_inst.got) begin
    chk("frame", expq.pop_front(), ascc_host_model_inst.rx[15:0]);
  end
  initial begin
    logic [7:0] c;
    logic [7:0] m;
    int k;
    void'($urandom(32'h3079));
    repeat (3) @(negedge clock);
    reset = 1'b0;
    repeat (5) @(negedge clock);
    // Every select code differential, then single-ended codes 0-3; modes rotate
    for (int i = 0; i < 12; i++) begin
      c = {1'b1, 3'(i), 1'($urandom), 1'(i >= 8), 2'(i)};
      @(negedge clock);
      result = 10'($urandom);
      sub = 2'($urandom);
      expq.push_back({1'b0, result ^ {~c[3], 9'h000}, sub, 3'h0});
      if (c[1:0] == MODE_EXT_CLK) begin
        ascc_host_model_inst.xfer(24, {c, 16'h0000});
      end else begin
        ascc_host_model_inst.xfer(8, {c, 16'h0000});
        chk("strobe low", 16'h0001, {14'h0000, strobe, converting});
        for (k = 0; k < 200 && strobe !== 1'b1; k++)
          @(negedge clock);
        if (k == 200) begin
          bad_count++;
          summarize();
        end
        ascc_host_model_inst.xfer(16, 24'h000000);
      end
      repeat (8) @(negedge clock);
      if (c[2])
        m = {1'b0, c[4], c[6], c[5], 4'h8};
      else
        m = {1'b0, c[5:4], c[6], 1'b0, c[5:4], ~c[6]};
      chk("mux", {7'h00, c[3], m}, {7'h00, analog.unipolar, analog.mux_positive,
        analog.mux_negative});
      chk("command", {9'h000, c[6:0]}, {9'h000, cmd});
      chk("float", {14'h0000, 1'b1, c[1:0] == MODE_EXT_CLK},
        {14'h0000, dout_oe_n, strobe_oe_n});
      chk("busy", 16'h0000, {15'h0000, converting});
    end
    // Deselect mid-conversion; the next command must restart cleanly
    ascc_host_model_inst.xfer(10, 24'hFF0000);
    @(negedge clock);
    result = 10'($urandom);
    expq.push_back({1'b0, result, sub, 3'h0});
    ascc_host_model_inst.xfer(24, 24'hFF0000);
    repeat (20) @(negedge clock);
    summarize();
  end
endmodule // ascc_core_bench
bind ascc_core ascc_core_properties #(.CONV_CYCLES(CONV_CYCLES)) ascc_core_properties_inst (
  .CLOCK(CLOCK), .RESET(RESET), .CHIP_SELECT_N(CHIP_SELECT_N), .SERIAL_CLOCK(SERIAL_CLOCK),
  .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SERIAL_DATA_OUT_OE_N(SERIAL_DATA_OUT_OE_N),
  .CONVERSION_STROBE(CONVERSION_STROBE), .CONVERSION_STROBE_OE_N(CONVERSION_STROBE_OE_N),
  .ANALOG_CONTROL(ANALOG_CONTROL), .ACTIVE_COMMAND(ACTIVE_COMMAND), .CONVERTING(CONVERTING));
